// File: design/nasel_sync.sv
// Two flip-flop synchroniser for a vector of asynchronous pins.
// Assumes the pins change slowly relative to the clock.
`timescale 1ns/1ps
module nasel_sync #(
  parameter int unsigned W = 4
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ----------------------------------------------------------------
  // Synchroniser stages
  // ----------------------------------------------------------------
  logic [W-1:0] meta_r;

  // The first stage feeds only the second stage, never logic.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

// File: design/nasel_top.sv
// Node address select: picks the module address from straps or stored value.
// Assumes straps and usb_present come from pins; the stored address and the
// factory-default request come from firmware logic on the same clock.
`timescale 1ns/1ps
module nasel_top #(
  parameter int unsigned BAUD_W = 20
) (
  input  wire logic                            clk,
  input  wire logic                            rst,
  input  wire logic                            strap_bit0,
  input  wire logic                            strap_bit1,
  input  wire logic                            strap_bit2,
  input  wire logic                            strap_bit3,
  input  wire logic [nasel_pkg::ADDR_W-1:0]    stored_addr,
  input  wire logic                            usb_present,
  input  wire logic                            factory_reset,
  input  wire logic [BAUD_W-1:0]               rs485_baud_req,
  input  wire logic                            baud_req_valid,
  input  wire logic                            aux_serial_pos,
  input  wire logic                            aux_serial_neg,
  output logic      [nasel_pkg::ADDR_W-1:0]    module_addr,
  output logic      [nasel_pkg::ADDR_W-1:0]    reply_addr,
  output logic                                 straps_active,
  output logic                                 addr_valid,
  output logic                                 can_enable,
  output logic      [BAUD_W-1:0]               rs485_baud,
  output logic                                 fw_update_allowed,
  output logic                                 motor_serial_rx
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [nasel_pkg::STRAP_W-1:0] strap_s;
  logic                          usb_s;
  logic                          aux_pos_s;
  logic                          aux_neg_s;

  // Strap one lands in bit 0 and strap four in bit 3.
  nasel_sync #(.W(nasel_pkg::STRAP_W)) u_sync_strap (
    .clk (clk),
    .rst (rst),
    .d   ({strap_bit3, strap_bit2, strap_bit1, strap_bit0}),
    .q   (strap_s)
  );

  // The USB and aux pins each get their own instance, so no bit position has to be remembered.
  nasel_sync #(.W(1)) u_sync_usb (
    .clk (clk),
    .rst (rst),
    .d   (usb_present),
    .q   (usb_s)
  );

  // The two aux legs are synchronised side by side and decoded only after
  // both have settled; a skew of one cycle between them shows as a short zero.
  nasel_sync #(.W(1)) u_sync_aux_pos (
    .clk (clk),
    .rst (rst),
    .d   (aux_serial_pos),
    .q   (aux_pos_s)
  );

  nasel_sync #(.W(1)) u_sync_aux_neg (
    .clk (clk),
    .rst (rst),
    .d   (aux_serial_neg),
    .q   (aux_neg_s)
  );

  // ----------------------------------------------------------------
  // Strap capture sequencing
  // ----------------------------------------------------------------
  localparam logic [1:0] SETTLE_MAX = 2'(nasel_pkg::SETTLE_CYC);

  nasel_pkg::nasel_state_type   state_r, state_nxt;
  logic [1:0]                   settle_r, settle_nxt;
  logic [nasel_pkg::ADDR_W-1:0] addr_r, addr_nxt;
  logic                         act_r, act_nxt;
  logic                         valid_r, valid_nxt;

  // Wait for the synchroniser to fill, capture once, then hold until reset.
  // Holding avoids an address change mid-frame if a slot strap bounces.
  always_comb begin
    state_nxt  = state_r;
    settle_nxt = settle_r;
    addr_nxt   = addr_r;
    act_nxt    = act_r;
    valid_nxt  = valid_r;
    case (state_r)
      nasel_pkg::NASEL_WAIT: begin
        if (settle_r == SETTLE_MAX) begin
          state_nxt = nasel_pkg::NASEL_CAPTURE;
        end else begin
          settle_nxt = settle_r + 2'h1;
        end
      end
      nasel_pkg::NASEL_CAPTURE: begin
        if (strap_s == nasel_pkg::STRAPS_UNUSED) begin
          addr_nxt = stored_addr;
          act_nxt  = 1'b0;
        end else begin
          addr_nxt = {{(nasel_pkg::ADDR_W-nasel_pkg::STRAP_W){1'b0}}, strap_s};
          act_nxt  = 1'b1;
        end
        valid_nxt = 1'b1;
        state_nxt = nasel_pkg::NASEL_HOLD;
      end
      nasel_pkg::NASEL_HOLD: begin
        state_nxt = nasel_pkg::NASEL_HOLD;
      end
      default: begin
        state_nxt = nasel_pkg::NASEL_WAIT;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r  <= nasel_pkg::NASEL_WAIT;
      settle_r <= '0;
      addr_r   <= nasel_pkg::ADDR_RESET;
      act_r    <= 1'b0;
      valid_r  <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      settle_r <= settle_nxt;
      addr_r   <= addr_nxt;
      act_r    <= act_nxt;
      valid_r  <= valid_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Serial rate selection
  // ----------------------------------------------------------------
  localparam logic [BAUD_W-1:0] BAUD_MAX = BAUD_W'(nasel_pkg::RS485_MAX_BPS);
  localparam logic [BAUD_W-1:0] BAUD_DEF = BAUD_W'(nasel_pkg::RS485_DEFAULT_BPS);

  logic [BAUD_W-1:0] baud_r, baud_nxt;

  // Requests above the hardware ceiling are clamped rather than refused,
  // so the link always stays inside what the transceiver can carry.
  always_comb begin
    baud_nxt = baud_r;
    if (factory_reset) begin
      baud_nxt = BAUD_DEF;
    end else if (baud_req_valid) begin
      if (rs485_baud_req > BAUD_MAX) begin
        baud_nxt = BAUD_MAX;
      end else begin
        baud_nxt = rs485_baud_req;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      baud_r <= BAUD_DEF;
    end else begin
      baud_r <= baud_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  logic                         pins_settled;
  logic [nasel_pkg::ADDR_W-1:0] module_addr_nxt;
  logic [nasel_pkg::ADDR_W-1:0] reply_addr_nxt;
  logic                         straps_active_nxt;
  logic                         addr_valid_nxt;
  logic                         can_enable_nxt;
  logic [BAUD_W-1:0]            rs485_baud_nxt;
  logic                         fw_update_allowed_nxt;
  logic                         motor_serial_rx_nxt;

  // The synchronisers leave reset at zero, which would read as USB absent and
  // as a driven zero on the aux line, a false start bit for the motor chip.
  // Until real pin values have passed both stages the outputs keep safe levels.
  assign pins_settled = (state_r != nasel_pkg::NASEL_WAIT) || (settle_r == SETTLE_MAX);

  // One address set serves both transports, so no per-link copy exists.
  // CAN is off while USB is attached; the aux line is differential in only,
  // and nothing here can drive it back towards the master.
  always_comb begin
    module_addr_nxt       = addr_r;
    reply_addr_nxt        = nasel_pkg::REPLY_ADDR;
    straps_active_nxt     = act_r;
    addr_valid_nxt        = valid_r;
    rs485_baud_nxt        = baud_r;
    fw_update_allowed_nxt = valid_r;
    can_enable_nxt        = 1'b0;
    motor_serial_rx_nxt   = 1'b1;
    if (pins_settled) begin
      can_enable_nxt      = ~usb_s;
      motor_serial_rx_nxt = aux_pos_s & ~aux_neg_s;
    end
  end

  // Registers only; every top output comes straight from one of these.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      module_addr       <= nasel_pkg::ADDR_RESET;
      reply_addr        <= nasel_pkg::REPLY_ADDR;
      straps_active     <= 1'b0;
      addr_valid        <= 1'b0;
      can_enable        <= 1'b0;
      rs485_baud        <= BAUD_DEF;
      fw_update_allowed <= 1'b0;
      motor_serial_rx   <= 1'b1;
    end else begin
      module_addr       <= module_addr_nxt;
      reply_addr        <= reply_addr_nxt;
      straps_active     <= straps_active_nxt;
      addr_valid        <= addr_valid_nxt;
      can_enable        <= can_enable_nxt;
      rs485_baud        <= rs485_baud_nxt;
      fw_update_allowed <= fw_update_allowed_nxt;
      motor_serial_rx   <= motor_serial_rx_nxt;
    end
  end

endmodule

// File: pkg/nasel_pkg.sv
// Constants for the node address select block.
// Assumes a single 20 MHz clock domain and no software register access.
//
// Summary of operation
// - All straps low selects stored address.
// - Any strap high selects strap address.
// - Native protocol address from straps, 1..15.
// - Native protocol reply address fixed 255.
// - Same addressing over CAN and RS485.
// - CANopen node ID from straps, 1..15.
// - Strap one is bit0, four bit3.
// - Aux serial input routed straight to motor chip.
// - Aux serial path is receive only.
// - CAN disabled while USB connected.
// - RS485 rate never above 1 Mbit/s.
// - Factory defaults give RS485 9600 bit/s.
// - Firmware update allowed over CAN or RS485.
package nasel_pkg;

  // ----------------------------------------------------------------
  // Address constants
  // ----------------------------------------------------------------
  localparam int unsigned STRAP_W       = 4;
  localparam int unsigned ADDR_W        = 8;
  localparam logic [7:0]  REPLY_ADDR    = 8'hFF;
  localparam logic [3:0]  STRAPS_UNUSED = 4'h0;
  localparam logic [7:0]  ADDR_RESET    = 8'h01;

  // ----------------------------------------------------------------
  // Serial rate constants in bit/s, then the clock in Hz and the settle time in cycles
  // ----------------------------------------------------------------
  localparam int unsigned RS485_MAX_BPS     = 1000000;
  localparam int unsigned RS485_DEFAULT_BPS = 9600;
  localparam int unsigned CLK_HZ            = 20000000;
  localparam int unsigned SETTLE_CYC        = 2;

  // Start-up sequencing of the strap capture.
  typedef enum logic [1:0] {
    NASEL_WAIT,
    NASEL_CAPTURE,
    NASEL_HOLD
  } nasel_state_type;

endpackage

// File: verification/nasel_checker.sv
// Checker watching the ports of the node address select top.
// Assumes one clock with an asynchronous active-high reset.
`timescale 1ns/1ps
module nasel_checker #(
  parameter int unsigned BAUD_W = 20
) (
  input wire logic                         clk,
  input wire logic                         rst,
  input wire logic                         usb_present,
  input wire logic                         factory_reset,
  input wire logic                         aux_serial_pos,
  input wire logic                         aux_serial_neg,
  input wire logic [nasel_pkg::ADDR_W-1:0] module_addr,
  input wire logic [nasel_pkg::ADDR_W-1:0] reply_addr,
  input wire logic                         straps_active,
  input wire logic                         addr_valid,
  input wire logic                         can_enable,
  input wire logic [BAUD_W-1:0]            rs485_baud,
  input wire logic                         fw_update_allowed,
  input wire logic                         motor_serial_rx
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  // Pins pass a synchroniser, so they must hold four edges before outputs follow.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_usb_on; usb_present [*4]; endsequence
  sequence s_aux_one; (aux_serial_pos && !aux_serial_neg) [*4]; endsequence
  sequence s_aux_zero; (!aux_serial_pos) [*4]; endsequence
  a_reply_fixed: assert property (reply_addr == 8'hff) else $error("reply address moved");
  a_strap_range: assert property (straps_active && addr_valid |-> module_addr inside {[8'h01:8'h0f]})
    else $error("strap address out of range");
  a_addr_held: assert property (addr_valid && $past(addr_valid) |-> $stable(module_addr) && $stable(straps_active))
    else $error("address changed after capture");
  a_valid_stays: assert property (addr_valid |=> addr_valid) else $error("address valid dropped");
  a_can_off: assert property (s_usb_on |-> !can_enable) else $error("CAN on with USB");
  a_baud_max: assert property (rs485_baud <= nasel_pkg::RS485_MAX_BPS) else $error("rate above limit");
  a_factory_rate: assert property (factory_reset |-> ##2 rs485_baud == 20'h2580)
    else $error("factory rate wrong");
  a_fw_allowed: assert property (addr_valid |-> fw_update_allowed) else $error("update blocked");
  a_aux_high: assert property (s_aux_one |-> motor_serial_rx) else $error("aux one lost");
  a_aux_low: assert property (s_aux_zero |-> !motor_serial_rx) else $error("aux zero lost");
endmodule

// File: verification/nasel_slot.sv
// Model of the base-board slot: strap pins and the write-only aux master.
// Assumes the bench changes slot and tx_bit at falling clock edges.
`timescale 1ns/1ps
module nasel_slot (
  input  wire logic [3:0] slot,
  input  wire logic       tx_bit,
  output logic            strap_bit0,
  output logic            strap_bit1,
  output logic            strap_bit2,
  output logic            strap_bit3,
  output logic            aux_serial_pos,
  output logic            aux_serial_neg
);
  // ------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------
  // Each strap carries one binary weight of the slot number; slot 0 leaves all low.
  assign {strap_bit3, strap_bit2, strap_bit1, strap_bit0} = slot;
  // The master only transmits, so the model has no receive side at all.
  assign aux_serial_pos = tx_bit;
  assign aux_serial_neg = ~tx_bit;
endmodule

// File: verification/nasel_top_test.sv
// Self-checking bench for the node address select top.
// Assumes the slot model drives the strap and aux pins and the bench drives the USB pin and firmware inputs.
`timescale 1ns/1ps
module nasel_top_test;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic [3:0]  slot = 4'h0;
  logic        tx_bit = 1'h1;
  logic [7:0]  stored = 8'h00;
  logic        usb = 1'h0;
  logic        fac = 1'h0;
  logic [19:0] req = 20'h0_0000;
  logic        req_v = 1'h0;
  logic        s0, s1, s2, s3, ap, an, act, vld, can, fw, mrx;
  logic [7:0]  module_addr, reply_addr;
  logic [19:0] rs485_baud;
  int          num_errors = 0;
  int          num_checks = 0;
  int          cycles = 0;
  // ------------------------------------------------------------
  // Clock, timeout, instances
  // ------------------------------------------------------------
  // The ceiling is far above the roughly 370 cycles the sequence needs.
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      stop_test();
    end
  end
  nasel_slot slot_u (.slot(slot), .tx_bit(tx_bit), .strap_bit0(s0), .strap_bit1(s1), .strap_bit2(s2),
    .strap_bit3(s3), .aux_serial_pos(ap), .aux_serial_neg(an));
  nasel_top #(.BAUD_W(20)) dut_u (.clk(clk), .rst(rst), .strap_bit0(s0), .strap_bit1(s1), .strap_bit2(s2),
    .strap_bit3(s3), .stored_addr(stored), .usb_present(usb), .factory_reset(fac), .rs485_baud_req(req),
    .baud_req_valid(req_v), .aux_serial_pos(ap), .aux_serial_neg(an), .module_addr(module_addr),
    .reply_addr(reply_addr), .straps_active(act), .addr_valid(vld), .can_enable(can), .rs485_baud(rs485_baud),
    .fw_update_allowed(fw), .motor_serial_rx(mrx));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] exp_addr(input logic [3:0] s, input logic [7:0] st);
    return (s != 4'h0) ? {4'h0, s} : st;
  endfunction
  function automatic logic [19:0] exp_rate(input logic [19:0] r, input logic f);
    if (f) return 20'(nasel_pkg::RS485_DEFAULT_BPS);
    return (r > 20'(nasel_pkg::RS485_MAX_BPS)) ? 20'(nasel_pkg::RS485_MAX_BPS) : r;
  endfunction
  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'h1) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  // The answer lands two edges after the request edge.
  task automatic set_rate(input logic [19:0] r, input logic f);
    @(negedge clk) req = r;
    req_v = 1'h1;
    fac = f;
    @(negedge clk) req_v = 1'h0;
    fac = 1'h0;
    @(negedge clk) check(rs485_baud === exp_rate(r, f), "rate");
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  // Every slot number is tried across a fresh reset, then the straps move to prove the hold.
  initial begin
    void'($urandom(4));
    for (int k = 0; k < 16; k++) begin
      @(negedge clk) rst = 1'h1;
      slot = k[3:0];
      stored = 8'($urandom_range(255, 1));
      usb = k[0];
      tx_bit = k[1];
      repeat (4) @(negedge clk);
      rst = 1'h0;
      repeat (2) @(negedge clk);
      check(vld === 1'h0 && module_addr === nasel_pkg::ADDR_RESET, "early");
      repeat (6) @(negedge clk);
      check(module_addr === exp_addr(slot, stored), "address");
      check(act === (k != 0) && reply_addr === 8'hff && fw === 1'h1, "flags");
      check(rs485_baud === 20'h2580, "reset rate");
      check(vld === 1'h1 && can === ~usb && mrx === tx_bit, "pins");
      slot = ~slot;
      stored = ~stored;
      repeat (6) @(negedge clk);
      check(module_addr === exp_addr(~slot, ~stored), "hold");
    end
    set_rate(20'hF_4240, 1'h0);
    set_rate(20'hF_4241, 1'h0);
    set_rate(20'hF_FFFF, 1'h1);
    repeat (12) begin
      usb = 1'($urandom);
      tx_bit = 1'($urandom);
      set_rate(20'($urandom_range(20'hF_FFFF, 0)), 1'($urandom_range(3, 0) == 0));
      repeat (2) @(negedge clk);
      check(can === ~usb, "can");
      check(mrx === tx_bit, "aux");
    end
    stop_test();
  end
endmodule
bind nasel_top nasel_checker #(.BAUD_W(BAUD_W)) chk_u (.clk(clk), .rst(rst), .usb_present(usb_present),
  .factory_reset(factory_reset), .aux_serial_pos(aux_serial_pos), .aux_serial_neg(aux_serial_neg),
  .module_addr(module_addr), .reply_addr(reply_addr), .straps_active(straps_active), .addr_valid(addr_valid),
  .can_enable(can_enable), .rs485_baud(rs485_baud), .fw_update_allowed(fw_update_allowed),
  .motor_serial_rx(motor_serial_rx));
